// *** design/conv_cfg_device.sv ***
// Behaviour
// (R01) power mode 0 normal, 3 power-down
// (R02) class code fixed, read-only low nibble
// (R03) part identifier fixed sixteen-bit read-only
// (R04) maker identifier fixed sixteen-bit read-only
// (R05) address hold freezes streaming address
// (R06) ascend bit picks increment or decrement
// (R07) processor enable lets reference events act
// (R08) receiver enable turns on reference receiver
// (R09) host sets receiver before processor enable; the host sets both in the same write
// (R10) fine scale shrinks window delay steps
// (R11) host uses fine scale at high rates; the host never sets the fine scale bit itself
// (R12) delay select chooses applied capture delay
// (R13) host keeps delay select zero for calibration; the host passes delay select as software set it
// (R14) polarity bit inverts aligned reference
// (R15) timestamp source bit selects reference input
// (R16) reference on sample lsb when both enabled
// (R17) dc-coupled modes for clock and reference
// (R18) reserved bits kept, id writes ignored
module conv_cfg_device #(
    parameter int           SAMPLE_W   = 12,
    parameter logic [3:0]   CLASS_CODE = 4'h5,     // arbitrary value
    parameter logic [15:0]  PART_ID    = 16'h1234, // arbitrary value
    parameter logic [15:0]  MAKER_ID   = 16'h5a5a  // arbitrary value
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // serial link
    spi_link_if.device                link,
    // converter side
    input  wire logic                 sync_reference,
    input  wire logic                 timestamp_output_enable,
    input  wire logic [SAMPLE_W-1:0]  sample_in,
    output logic                      power_down,
    output logic                      sync_ref_receiver_enable,
    output logic                      sync_ref_processor_enable,
    output logic                      window_fine_scale,
    output logic [3:0]                capture_delay_select,
    output logic                      ref_as_timestamp_enable,
    output logic                      clock_dc_coupled_enable,
    output logic                      ref_dc_coupled_enable,
    output logic                      ref_polarity_invert,
    output logic                      sync_ref_event,
    output logic [SAMPLE_W-1:0]       sample_out
);
    import conv_cfg_pkg::*;

    initial begin
        if (SAMPLE_W < 2) $error("sample width too small");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]          if_cfg;      // ascend and reserved bits
        logic [7:0]          pwr_cfg;     // power mode and reserved
        logic [3:0]          class_rsv;   // writable upper nibble
        logic [7:0]          usr_cfg;     // address hold and reserved
        logic [7:0]          ref_ctl;     // sync reference control
        logic [7:0]          rcv_ctl;     // input receiver control
        logic                pd;
        logic                sclk_prev;   // last sampled serial clock
        logic                in_data;     // header done, data bytes
        logic [4:0]          cnt;         // bit count in unit
        logic [14:0]         shin;        // incoming shift
        logic                rd;          // frame is a read
        logic [14:0]         addr;        // current byte address
        logic [7:0]          tx;          // outgoing shift
        logic                sdo;         // serial data out
        logic                ref_prev;    // aligned reference history
        logic                evt;         // reference event pulse
        logic [SAMPLE_W-1:0] smp;         // sample out
    } dev_state_t;

    dev_state_t s_q;                      // registered state
    dev_state_t s_d;                      // next state

    // ==========================================================
    // register read decode, used for header and each next byte
    function automatic logic [7:0] read_byte(input logic [14:0] a, input dev_state_t s);
        case (a)
            ADDR_SERIAL_IF_CONFIG:     read_byte = s.if_cfg;
            ADDR_DEVICE_POWER_CONFIG:  read_byte = s.pwr_cfg;
            ADDR_DEVICE_CLASS_CODE:    read_byte = {s.class_rsv, CLASS_CODE};  // R02
            ADDR_PART_IDENTIFIER:      read_byte = PART_ID[7:0];               // R03
            ADDR_PART_IDENTIFIER + 15'h0001:  read_byte = PART_ID[15:8];       // R03
            ADDR_MAKER_IDENTIFIER:     read_byte = MAKER_ID[7:0];              // R04
            ADDR_MAKER_IDENTIFIER + 15'h0001: read_byte = MAKER_ID[15:8];      // R04
            ADDR_SERIAL_PORT_USER_CFG: read_byte = s.usr_cfg;
            ADDR_SYNC_REF_CONTROL:     read_byte = s.ref_ctl;
            ADDR_INPUT_RECEIVER_CTRL:  read_byte = s.rcv_ctl;
            default:                   read_byte = RST_BYTE;
        endcase
    endfunction : read_byte

    // next streaming address
    function automatic logic [14:0] step_addr(input logic [14:0] a, input dev_state_t s);
        if (s.usr_cfg[BIT_ADDR_HOLD]) begin
            step_addr = a;                                     // R05
        end else if (s.if_cfg[BIT_ADDR_ASCEND]) begin
            step_addr = a + 15'h0001;                          // R06
        end else begin
            step_addr = a - 15'h0001;                          // R06
        end
    endfunction : step_addr

    // ==========================================================
    // next-state logic
    always_comb begin
        logic        rise;
        logic        fall;
        logic [7:0]  wbyte;
        logic [14:0] na;
        logic        aligned;
        rise    = 1'b0;
        fall    = 1'b0;
        wbyte   = RST_BYTE;
        na      = '0;
        aligned = 1'b0;
        s_d = s_q;
        s_d.sclk_prev = link.sclk;
        rise = link.sclk & ~s_q.sclk_prev;
        fall = ~link.sclk & s_q.sclk_prev;
        // serial frame handling
        if (link.cs_n) begin
            // idle: ready for a new header
            s_d.in_data = 1'b0;
            s_d.cnt     = '0;
            s_d.sdo     = 1'b0;
        end else if (rise && !s_q.in_data) begin
            // header bits
            s_d.shin = {s_q.shin[13:0], link.sdi};
            s_d.cnt  = s_q.cnt + 5'd1;
            if (s_q.cnt == 5'(HDR_BITS - 1)) begin
                s_d.rd      = s_q.shin[14];
                s_d.addr    = {s_q.shin[13:0], link.sdi};
                s_d.tx      = read_byte({s_q.shin[13:0], link.sdi}, s_q);
                s_d.in_data = 1'b1;
                s_d.cnt     = '0;
            end
        end else if (rise) begin
            // data bits
            s_d.shin = {s_q.shin[13:0], link.sdi};
            s_d.cnt  = s_q.cnt + 5'd1;
            if (s_q.cnt == 5'(BYTE_BITS - 1)) begin
                wbyte    = {s_q.shin[6:0], link.sdi};
                s_d.cnt  = '0;
                na       = step_addr(s_q.addr, s_q);
                s_d.addr = na;
                if (!s_q.rd) begin
                    // id registers and unmapped bytes ignore writes
                    case (s_q.addr)                            // R18
                        ADDR_SERIAL_IF_CONFIG:     s_d.if_cfg    = wbyte;
                        ADDR_DEVICE_POWER_CONFIG:  s_d.pwr_cfg   = wbyte;
                        ADDR_DEVICE_CLASS_CODE:    s_d.class_rsv = wbyte[7:4];
                        ADDR_SERIAL_PORT_USER_CFG: s_d.usr_cfg   = wbyte;
                        ADDR_SYNC_REF_CONTROL:     s_d.ref_ctl   = wbyte;
                        ADDR_INPUT_RECEIVER_CTRL:  s_d.rcv_ctl   = wbyte;
                        default:                   s_d.usr_cfg   = s_q.usr_cfg;
                    endcase
                end
                s_d.tx = read_byte(na, s_d);
            end
        end else if (fall && s_q.in_data) begin
            // present next read bit while clock is low
            s_d.sdo = s_q.rd & s_q.tx[7];
            s_d.tx  = {s_q.tx[6:0], 1'b0};
        end
        s_d.pd = (s_d.pwr_cfg[1:0] == MODE_POWER_DOWN); // R01
        // reference path: receiver gates, polarity applies
        aligned = s_q.ref_ctl[BIT_RECV_EN] &                   // R08
                  (sync_reference ^ s_q.rcv_ctl[BIT_REF_INVERT]); // R14
        s_d.ref_prev = aligned;
        s_d.evt = s_q.ref_ctl[BIT_PROC_EN] & aligned & ~s_q.ref_prev; // R07
        // sample lsb carries reference when both enables set
        s_d.smp = sample_in;
        if (s_q.rcv_ctl[BIT_REF_TIMESTAMP] && timestamp_output_enable) begin
            s_d.smp[0] = aligned;                              // R15 R16
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q         <= '0;
            s_q.if_cfg  <= RST_SERIAL_IF_CONFIG;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from state
    assign link.sdo                  = s_q.sdo;
    assign power_down                = s_q.pd;  // R01
    assign sync_ref_receiver_enable  = s_q.ref_ctl[BIT_RECV_EN];               // R08
    assign sync_ref_processor_enable = s_q.ref_ctl[BIT_PROC_EN];               // R07
    assign window_fine_scale         = s_q.ref_ctl[BIT_FINE_SCALE];            // R10
    assign capture_delay_select      = s_q.ref_ctl[3:0];                       // R12
    assign ref_as_timestamp_enable   = s_q.rcv_ctl[BIT_REF_TIMESTAMP];         // R15
    assign clock_dc_coupled_enable   = s_q.rcv_ctl[BIT_CLOCK_DC];              // R17
    assign ref_dc_coupled_enable     = s_q.rcv_ctl[BIT_REF_DC];                // R17
    assign ref_polarity_invert       = s_q.rcv_ctl[BIT_REF_INVERT];            // R14
    assign sync_ref_event            = s_q.evt;
    assign sample_out                = s_q.smp;
endmodule : conv_cfg_device

// *** design/conv_cfg_host.sv ***
module conv_cfg_host #(
    parameter int SCLK_HALF = 4   // hclk cycles per serial clock half period
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // system bus slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial link
    spi_link_if.host         link
);
    import conv_cfg_pkg::*;

    initial begin
        if (SCLK_HALF < 2 || SCLK_HALF > 255) $error("serial clock divider out of range");
    end

    // ==========================================================
    // state
    typedef enum logic [1:0] {IDLE, SHIFT, GAP} host_phase_t;

    typedef struct packed {
        host_phase_t  ph;         // engine phase
        logic         wr_pend;    // bus write in data phase
        logic [7:0]   wr_addr;    // captured bus address
        logic [31:0]  rdata;      // bus read data
        logic [15:0]  cmd;        // read flag and address
        logic [7:0]   wdat;       // byte to write
        logic [7:0]   rbyte;      // byte read back
        logic [23:0]  tx;         // outgoing frame
        logic [7:0]   rx;         // incoming byte
        logic [7:0]   div;        // half period count
        logic [4:0]   bits;       // bits finished
        logic         sclk;       // serial clock
        logic         cs_n;       // frame select
    } host_state_t;

    host_state_t s_q;             // registered state
    host_state_t s_d;             // next state

    // ==========================================================
    // bus register read decode
    function automatic logic [31:0] bus_read(input logic [7:0] a, input host_state_t s);
        case (a)
            REG_CMD:    bus_read = {16'h0000, s.cmd};
            REG_DATA:   bus_read = {24'h000000, s.rbyte};
            REG_STATUS: bus_read = {31'h00000000, s.ph != IDLE};
            default:    bus_read = 32'h00000000;
        endcase
    endfunction : bus_read

    // ==========================================================
    // next-state logic
    always_comb begin
        logic [7:0] wb;
        wb = '0;
        s_d = s_q;
        // bus address phase
        s_d.wr_pend = 1'b0;
        if (hsel && htrans == HTRANS_NONSEQ) begin
            s_d.wr_pend = hwrite;
            s_d.wr_addr = haddr;
            if (!hwrite) begin
                s_d.rdata = bus_read(haddr, s_q);
            end
        end
        // bus data phase; commands while busy are dropped
        if (s_q.wr_pend && s_q.ph == IDLE) begin
            if (s_q.wr_addr == REG_DATA) begin
                s_d.wdat = hwdata[7:0];
            end else if (s_q.wr_addr == REG_CMD) begin
                s_d.cmd = hwdata[15:0];
                wb = s_q.wdat;  // delay select passes as software set it (R13)
                // receiver enable goes out with processor enable
                if (hwdata[14:0] == ADDR_SYNC_REF_CONTROL && wb[BIT_PROC_EN]) begin
                    wb[BIT_RECV_EN] = 1'b1;                    // R09
                end
                s_d.tx   = {hwdata[15:0], wb};
                s_d.ph   = SHIFT;
                s_d.cs_n = 1'b0;
                s_d.div  = '0;
                s_d.bits = '0;
            end
        end
        // serial engine
        case (s_q.ph)
            IDLE: begin
                s_d.sclk = 1'b0;
            end
            SHIFT: begin
                s_d.div = s_q.div + 8'd1;
                if (s_q.div == 8'(SCLK_HALF - 1)) begin
                    s_d.div  = '0;
                    s_d.sclk = ~s_q.sclk;
                    if (!s_q.sclk) begin
                        s_d.rx = {s_q.rx[6:0], link.sdo};
                    end else begin
                        s_d.tx   = {s_q.tx[22:0], 1'b0};
                        s_d.bits = s_q.bits + 5'd1;
                        if (s_q.bits == 5'(FRAME_BITS - 1)) begin
                            s_d.ph   = GAP;
                            s_d.cs_n = 1'b1;
                            if (s_q.cmd[BIT_CMD_READ]) begin
                                s_d.rbyte = s_q.rx;
                            end
                        end
                    end
                end
            end
            GAP: begin
                // select stays high one half period between frames
                s_d.div = s_q.div + 8'd1;
                if (s_q.div == 8'(SCLK_HALF - 1)) begin
                    s_d.ph = IDLE;
                end
            end
            default: s_d.ph = IDLE;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q      <= '0;
            s_q.ph   <= IDLE;
            s_q.cs_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from state
    assign hrdata    = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign link.sclk = s_q.sclk;
    assign link.cs_n = s_q.cs_n;
    assign link.sdi  = s_q.tx[23];
endmodule : conv_cfg_host

// *** include/conv_cfg_pkg.sv ***
package conv_cfg_pkg;
    // ==========================================================
    // serial register map of the converter
    localparam logic [14:0] ADDR_SERIAL_IF_CONFIG     = 15'h0000;
    localparam logic [14:0] ADDR_DEVICE_POWER_CONFIG  = 15'h0002;
    localparam logic [14:0] ADDR_DEVICE_CLASS_CODE    = 15'h0003;
    localparam logic [14:0] ADDR_PART_IDENTIFIER      = 15'h0004;
    localparam logic [14:0] ADDR_MAKER_IDENTIFIER     = 15'h000c;
    localparam logic [14:0] ADDR_SERIAL_PORT_USER_CFG = 15'h0010;
    localparam logic [14:0] ADDR_SYNC_REF_CONTROL     = 15'h0029;
    localparam logic [14:0] ADDR_INPUT_RECEIVER_CTRL  = 15'h002a;
    // ==========================================================
    // reset values
    localparam logic [7:0]  RST_SERIAL_IF_CONFIG      = 8'h20;
    localparam logic [7:0]  RST_BYTE                  = 8'h00;
    // ==========================================================
    // field positions
    localparam int          BIT_ADDR_ASCEND           = 5;
    localparam int          BIT_ADDR_HOLD             = 0;
    localparam int          BIT_PROC_EN               = 6;
    localparam int          BIT_RECV_EN               = 5;
    localparam int          BIT_FINE_SCALE            = 4;
    localparam int          BIT_REF_TIMESTAMP         = 3;
    localparam int          BIT_CLOCK_DC              = 2;
    localparam int          BIT_REF_DC                = 1;
    localparam int          BIT_REF_INVERT            = 0;
    localparam logic [1:0]  MODE_NORMAL               = 2'h0;
    localparam logic [1:0]  MODE_POWER_DOWN           = 2'h3;
    // ==========================================================
    // serial frame layout: read flag, 15-bit address, then bytes
    localparam int          HDR_BITS                  = 16;
    localparam int          BYTE_BITS                 = 8;
    localparam int          FRAME_BITS                = 24;
    // ==========================================================
    // controller registers on the system bus (byte addresses)
    localparam logic [7:0]  REG_CMD                   = 8'h00;
    localparam logic [7:0]  REG_DATA                  = 8'h04;
    localparam logic [7:0]  REG_STATUS                = 8'h08;
    localparam int          BIT_CMD_READ              = 15;
    localparam logic [1:0]  HTRANS_NONSEQ             = 2'h2;
endpackage : conv_cfg_pkg

// *** include/spi_link_if.sv ***
interface spi_link_if;
    logic sclk;   // serial clock, made by the host
    logic cs_n;   // frame select, active low
    logic sdi;    // host to device data
    logic sdo;    // device to host data
    modport device (input sclk, input cs_n, input sdi, output sdo);
    modport host   (output sclk, output cs_n, output sdi, input sdo);
endinterface : spi_link_if

// *** tb/conv_cfg_link_checker.sv ***
// ==========================================================
// serial link checker, watches the wire between both ends
module conv_cfg_link_checker #(
    parameter int SCLK_HALF = 4   // host half period in hclk cycles
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] rise_q;   // sclk rises seen in this frame
    logic [7:0] run_q;    // cycles since sclk last moved
    logic       rd_q;     // read flag of the current frame

    // ==========================================================
    // frame bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_q <= 5'h00;
            run_q  <= 8'h00;
            rd_q   <= 1'b0;
        end else begin
            // restart the run count whenever sclk moves, saturate otherwise
            run_q <= $changed(sclk) ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
            if (cs_n) begin
                rise_q <= 5'h00;
            end else if ($rose(sclk)) begin
                rise_q <= rise_q + 5'h01;
                // first bit of the header is the read flag
                if (rise_q == 5'h00) begin
                    rd_q <= sdi;
                end
            end
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // select stays high for a gap after each frame
    sequence quiet_gap_s;
        cs_n [*2];
    endsequence
    // clock starts shortly after select falls
    sequence first_rise_s;
        !sclk ##[1:16] sclk;
    endsequence

    idle_clock_low_a: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    idle_data_low_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !sdo)
        else $error("device data not low outside a frame");
    half_period_a: assert property ($changed(sclk) && rise_q != 5'h00 |-> run_q == 8'(SCLK_HALF - 1))
        else $error("serial clock half period wrong");
    sdi_steady_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("host data moved while clock high");
    sdo_steady_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdo))
        else $error("device data moved while clock high");
    frame_length_a: assert property ($rose(cs_n) |-> rise_q == 5'd24)
        else $error("frame did not carry 24 clock pulses");
    frame_gap_a: assert property ($rose(cs_n) |-> quiet_gap_s)
        else $error("frames too close together");
    frame_start_a: assert property ($fell(cs_n) |-> first_rise_s)
        else $error("serial clock late after select");
    header_quiet_a: assert property (!cs_n && rise_q < 5'd16 |-> !sdo)
        else $error("device drove data during header");
    write_quiet_a: assert property (!cs_n && !rd_q && rise_q > 5'd1 |-> !sdo)
        else $error("device drove data in a write frame");
endmodule : conv_cfg_link_checker

// *** tb/testbench.sv ***
// ==========================================================
// bench top: host and device joined by the serial link
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_cfg_pkg::*;
    localparam logic [3:0]  CLASS = 4'h5;     // arbitrary value
    localparam logic [15:0] PART  = 16'h1234; // arbitrary value
    localparam logic [15:0] MAKER = 16'h5a5a; // arbitrary value
    // register map walk: address and value after reset
    localparam logic [14:0] RA [10] = '{15'h000, 15'h002, 15'h003, 15'h004, 15'h005, 15'h00c, 15'h00d,
                                        15'h010, 15'h029, 15'h02a};
    localparam logic [7:0]  RV [10] = '{8'h20, 8'h00, {4'h0, CLASS}, PART[7:0], PART[15:8], MAKER[7:0],
                                        MAKER[15:8], 8'h00, 8'h00, 8'h00};
    // write table: address, data, read back, expected control outputs
    localparam logic [14:0] WA [9] = '{15'h002, 15'h002, 15'h029, 15'h029, 15'h02a, 15'h02a, 15'h02a,
                                       15'h02a, 15'h02a};
    localparam logic [7:0]  WD [9] = '{8'h03, 8'hfe, 8'h40, 8'h9a, 8'h01, 8'h02, 8'h04, 8'h08, 8'hf0};
    localparam logic [7:0]  WB [9] = '{8'h03, 8'hfe, 8'h60, 8'h9a, 8'h01, 8'h02, 8'h04, 8'h08, 8'hf0};
    localparam logic [11:0] WC [9] = '{12'h800, 12'h000, 12'h600, 12'h1a0, 12'h1a1, 12'h1a2, 12'h1a4,
                                       12'h1a8, 12'h1a0};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        sync_reference, timestamp_output_enable, power_down, sync_ref_receiver_enable;
    logic        sync_ref_processor_enable, window_fine_scale, ref_as_timestamp_enable, sync_ref_event;
    logic        clock_dc_coupled_enable, ref_dc_coupled_enable, ref_polarity_invert;
    logic [3:0]  capture_delay_select;
    logic [11:0] sample_in, sample_out, cfg_w;
    int          miscompares, tests_run;

    spi_link_if link ();
    // control outputs gathered in register bit order
    assign cfg_w = {power_down, sync_ref_processor_enable, sync_ref_receiver_enable, window_fine_scale,
                    capture_delay_select, ref_as_timestamp_enable, clock_dc_coupled_enable,
                    ref_dc_coupled_enable, ref_polarity_invert};

    conv_cfg_host conv_cfg_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                                   .hrdata, .hreadyout, .hresp, .link);
    conv_cfg_device #(.CLASS_CODE(CLASS), .PART_ID(PART), .MAKER_ID(MAKER)) conv_cfg_device_i (
        .hclk, .hresetn, .link, .sync_reference, .timestamp_output_enable, .sample_in, .power_down,
        .sync_ref_receiver_enable, .sync_ref_processor_enable, .window_fine_scale, .capture_delay_select,
        .ref_as_timestamp_enable, .clock_dc_coupled_enable, .ref_dc_coupled_enable, .ref_polarity_invert,
        .sync_ref_event, .sample_out);
    conv_cfg_link_checker conv_cfg_link_checker_i (.hclk, .hresetn, .sclk(link.sclk), .cs_n(link.cs_n),
                                                   .sdi(link.sdi), .sdo(link.sdo));

    // ==========================================================
    // comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // one single word transfer on the system bus
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : ahb

    // one device register access through the host engine
    task automatic dev(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [31:0] r;
        ahb(1'b1, REG_DATA, {24'h0, wd}, r);
        ahb(1'b1, REG_CMD, {16'h0, rd, a}, r);
        @(posedge hclk);
        r = 32'h1;
        // poll busy until the frame is over
        while (r[0] !== 1'b0) ahb(1'b0, REG_STATUS, 32'h0, r);
        ahb(1'b0, REG_DATA, 32'h0, r);
        q = r[7:0];
    endtask : dev

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        dev(1'b0, a, d, q);
    endtask : wr

    task automatic rd_exp(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        dev(1'b1, a, 8'h00, q);
        check({24'h0, q}, {24'h0, e});
    endtask : rd_exp

    // drive the reference level and count event pulses
    task automatic pulses(input logic lvl, input logic [31:0] exp);
        int n;
        n = 0;
        sync_reference <= lvl;
        repeat (12) begin
            @(posedge hclk);
            if (sync_ref_event === 1'b1) n++;
        end
        check(n, exp);
    endtask : pulses

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        #160000;
        miscompares++;
        end_of_test();
    end

    initial begin
        {hresetn, hsel, hwrite, sync_reference, haddr, htrans, hsize, hwdata} = '0;
        timestamp_output_enable = 1'b1;
        sample_in = 12'h5a4;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 10; i++) rd_exp(RA[i], RV[i]);
        for (int i = 2; i < 7; i++) wr(RA[i], 8'hff);
        for (int i = 2; i < 7; i++) rd_exp(RA[i], (i == 2) ? {4'hf, CLASS} : RV[i]);
        for (int i = 0; i < 9; i++) begin
            wr(WA[i], WD[i]);
            check({20'h0, cfg_w}, {20'h0, WC[i]});
            rd_exp(WA[i], WB[i]);
        end
        // reference events and timestamp on the sample lsb
        wr(15'h029, 8'h60);
        wr(15'h02a, 8'h08);
        pulses(1'b1, 32'd1);
        check({20'h0, sample_out}, 32'h5a5);
        wr(15'h02a, 8'h09);
        check({20'h0, sample_out}, 32'h5a4);
        pulses(1'b0, 32'd1);
        timestamp_output_enable <= 1'b0;
        repeat (3) @(posedge hclk);
        check({20'h0, sample_out}, 32'h5a4);
        wr(15'h029, 8'h20);
        pulses(1'b1, 32'd0);
        pulses(1'b0, 32'd0);
        check(32'(conv_cfg_device_i.s_q.addr), 32'h02a);
        wr(15'h000, 8'h00);
        wr(15'h029, 8'h20);
        check(32'(conv_cfg_device_i.s_q.addr), 32'h028);
        wr(15'h010, 8'h01);
        wr(15'h029, 8'h20);
        check(32'(conv_cfg_device_i.s_q.addr), 32'h029);
        end_of_test();
    end
endmodule : testbench
